// >>> rtl/swtc_pkg.sv
package swtc_pkg;

   // Clock rate and auto-behaviour timeouts
   localparam int unsigned CLK_HZ = 100_000_000; // System clock, 100 MHz
   localparam int unsigned TIMEOUT_SHORT_MS = 100; // Auto timeout, fast timespans
   localparam int unsigned TIMEOUT_LONG_MS = 500; // Auto timeout, slow timespans
   localparam int unsigned TIMEOUT_SHORT_CYCLES = TIMEOUT_SHORT_MS * (CLK_HZ / 1000);
   localparam int unsigned TIMEOUT_LONG_CYCLES = TIMEOUT_LONG_MS * (CLK_HZ / 1000);
   localparam int TIMER_W = 26; // Holds the long timeout count

   // Sample width of the power and rear-input words
   localparam int SAMPLE_W = 16;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00; // Behaviour, polarity, origin, mode
   localparam logic [7:0] OFF_LEVEL = 8'h04; // Trigger threshold
   localparam logic [7:0] OFF_HYST = 8'h08; // Hysteresis half band
   localparam logic [7:0] OFF_TRG = 8'h0c; // Host trigger command
   localparam logic [7:0] OFF_STATUS = 8'h10; // Trigger state
   localparam logic [7:0] OFF_THRESH = 8'h14; // Threshold in use
   localparam logic [7:0] OFF_COUNT = 8'h18; // Sweeps started
   localparam logic [7:0] OFF_NONE = 8'hff; // Decode of an unmapped address

   // Control register fields
   localparam int CTRL_BEH_LSB = 0; // Two bits
   localparam int CTRL_POL_BIT = 2; // 1 selects falling polarity
   localparam int CTRL_ORG_LSB = 4; // Three bits
   localparam int CTRL_PULSE_BIT = 8; // Pulse acquisition mode
   localparam int CTRL_SPAN_BIT = 9; // 1 selects the long timeout

   // Status register fields
   localparam int STAT_ARMED_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_HARM_BIT = 2;
   localparam int STAT_BUSP_BIT = 3;
   localparam int STAT_FORCED_BIT = 4;

   // Values after reset
   localparam logic [31:0] CTRL_RST = 32'h0000_0101; // Auto, rising, probe one, pulse
   localparam logic [15:0] LEVEL_RST = 16'h0000;
   localparam logic [15:0] HYST_RST = 16'h0010;

   // Trigger behaviours
   typedef enum logic [1:0] {
      edge_only_behaviour,
      auto_behaviour,
      midpoint_tracking_behaviour
   } swtc_beh_t;

   // Trigger origins
   typedef enum logic [2:0] {
      probe_one_origin,
      probe_two_origin,
      rear_input_origin,
      immediate_origin,
      bus_origin,
      host_armed_probe_one,
      host_armed_probe_two,
      host_armed_rear_input
   } swtc_origin_t;

   // Sampled signals arriving from the acquisition front end
   typedef struct packed {
      logic valid;
      logic signed [SAMPLE_W-1:0] probe_one;
      logic signed [SAMPLE_W-1:0] probe_two;
      logic signed [SAMPLE_W-1:0] rear;
   } swtc_samples_t;

   // Decoded control settings
   typedef struct packed {
      swtc_beh_t beh;
      logic falling_polarity;
      swtc_origin_t origin;
      logic pulse_mode;
      logic long_span;
   } swtc_cfg_t;

endpackage : swtc_pkg

// >>> rtl/swtc_edge_detect.sv
`timescale 1ns/1ns

// Threshold comparator with hysteresis, gives one pulse per qualifying crossing
module swtc_edge_detect (
   input wire logic sys_clk, // System clock
   input wire logic srst, // Synchronous reset, active high
   input wire logic sample_valid, // New sample this cycle
   input wire logic signed [15:0] sample, // Selected source sample
   input wire logic signed [15:0] threshold, // Threshold in use
   input wire logic [15:0] hyst, // Half width of the hysteresis band
   input wire logic falling_polarity, // 1 for downward crossings
   output logic edge_pulse // One cycle per qualifying crossing
);

   logic above; // Last side of the band seen
   logic known; // A side has been seen since reset
   logic signed [17:0] s_x; // Widened sample
   logic signed [17:0] hi_lim; // Upper edge of the band
   logic signed [17:0] lo_lim; // Lower edge of the band

   // Band limits, widened so they never wrap
   always_comb begin
      s_x = {{2{sample[15]}}, sample};
      hi_lim = {{2{threshold[15]}}, threshold} + $signed({2'b00, hyst});
      lo_lim = {{2{threshold[15]}}, threshold} - $signed({2'b00, hyst});
   end

   // Side tracking and crossing detection
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         above <= 1'b0;
         known <= 1'b0;
         edge_pulse <= 1'b0;
      end else begin
         edge_pulse <= 1'b0;
         if (sample_valid) begin
            if (s_x >= hi_lim) begin
               // Upward swing past the band
               above <= 1'b1;
               known <= 1'b1;
               edge_pulse <= known & ~above & ~falling_polarity;
            end else if (s_x <= lo_lim) begin
               // Downward swing past the band
               above <= 1'b0;
               known <= 1'b1;
               edge_pulse <= known & above & falling_polarity;
            end
         end
      end
   end

endmodule : swtc_edge_detect

// >>> rtl/swtc_sweep_trigger.sv
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns

// Notes on behaviour
// - Edge-only: sweep on each qualifying crossing
// - Edge-only: no crossing means no sweep
// - Auto: force sweep after 100 or 500 ms
// - Midpoint: auto, threshold halfway between extremes
// - Threshold write cancels midpoint, selects auto
// - Midpoint tracking only with probe origins
// - Rising polarity triggers on upward crossings only
// - Falling polarity triggers on downward crossings only
// - Probe origins use probe one or two
// - External origin uses rear trigger input
// - Immediate origin starts sweep whenever armed
// - Bus origin: host command starts a sweep
// - Host-armed origins: command arms, edge starts
// - Settings act only in pulse acquisition mode
// - Comparator has a small hysteresis band
module swtc_sweep_trigger #(
   parameter int unsigned TIMEOUT_SHORT = swtc_pkg::TIMEOUT_SHORT_CYCLES, // Fast timeout
   parameter int unsigned TIMEOUT_LONG = swtc_pkg::TIMEOUT_LONG_CYCLES // Slow timeout
) (
   input wire logic sys_clk, // System clock, 100 MHz
   input wire logic srst, // Synchronous reset, active high
   input wire logic hsel, // AHB slave select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write flag
   input wire logic [2:0] hsize, // AHB transfer size
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB bus ready
   output logic hreadyout, // AHB slave ready
   output logic [31:0] hrdata, // AHB read data
   output logic hresp, // AHB response, always OKAY
   input wire swtc_pkg::swtc_samples_t samples, // Sampled power and rear input
   input wire logic sweep_done, // Acquisition finished its sweep
   output logic sweep_start, // One-cycle sweep start
   output logic trig_armed // Waiting for a trigger
);

   // Trigger states
   typedef enum logic {
      st_armed,
      st_sweep
   } swtc_state_t;

   swtc_state_t state; // Current trigger state
   logic [31:0] ctrl; // Control register
   logic signed [15:0] level; // Host threshold
   logic [15:0] hyst; // Hysteresis half band
   logic [31:0] sweep_count; // Sweeps started
   logic host_arm; // Host-armed trigger armed
   logic bus_pend; // Bus trigger waiting
   logic last_forced; // Last sweep came from the timeout
   logic [swtc_pkg::TIMER_W-1:0] timer; // Auto timeout counter
   logic signed [15:0] peak_max; // Highest tracked power
   logic signed [15:0] peak_min; // Lowest tracked power
   logic peak_seen; // Extremes hold real samples
   logic signed [15:0] thresh; // Threshold in use
   logic [7:0] wr_addr; // Latched write address
   logic wr_pend; // Write data phase this cycle
   swtc_pkg::swtc_cfg_t cfg; // Decoded control
   logic signed [15:0] src_sample; // Selected source sample
   logic edge_pulse; // Qualifying crossing
   logic edge_origin; // Origin watches a plain edge
   logic armed_origin; // Origin is host-armed
   logic probe_origin; // Origin uses a probe
   logic tracking; // Midpoint tracking active
   logic timeout_on; // Auto timeout applies
   logic [swtc_pkg::TIMER_W-1:0] limit; // Timeout in cycles
   logic fire_edge; // Start from an edge
   logic fire_force; // Start from the timeout
   logic fire_other; // Start from immediate or bus
   logic next_start; // Start a sweep this cycle
   logic trg_write; // Host trigger command
   logic signed [16:0] mid_sum; // Sum of extremes
   logic signed [15:0] next_thresh; // Next threshold in use
   logic addr_take; // Valid address phase
   logic [31:0] status_word; // Status register read value

   // Map a bus address to a register offset, or to the unmapped code
   function automatic logic [7:0] reg_decode(input logic [31:0] a);
      logic [7:0] w;
      w = {a[7:2], 2'b00};
      if (a[31:8] != 24'h00_0000) begin
         reg_decode = swtc_pkg::OFF_NONE;
      end else if (w <= swtc_pkg::OFF_COUNT) begin
         reg_decode = w;
      end else begin
         reg_decode = swtc_pkg::OFF_NONE;
      end
   endfunction : reg_decode

   // Control word split into its fields
   always_comb begin
      cfg.beh = swtc_pkg::swtc_beh_t'(ctrl[swtc_pkg::CTRL_BEH_LSB +: 2]);
      cfg.falling_polarity = ctrl[swtc_pkg::CTRL_POL_BIT];
      cfg.origin = swtc_pkg::swtc_origin_t'(ctrl[swtc_pkg::CTRL_ORG_LSB +: 3]);
      cfg.pulse_mode = ctrl[swtc_pkg::CTRL_PULSE_BIT];
      cfg.long_span = ctrl[swtc_pkg::CTRL_SPAN_BIT];
   end

   // Origin classes
   always_comb begin
      edge_origin = (cfg.origin == swtc_pkg::probe_one_origin) ||
                    (cfg.origin == swtc_pkg::probe_two_origin) ||
                    (cfg.origin == swtc_pkg::rear_input_origin);
      armed_origin = (cfg.origin == swtc_pkg::host_armed_probe_one) ||
                     (cfg.origin == swtc_pkg::host_armed_probe_two) ||
                     (cfg.origin == swtc_pkg::host_armed_rear_input);
      probe_origin = (cfg.origin == swtc_pkg::probe_one_origin) ||
                     (cfg.origin == swtc_pkg::probe_two_origin) ||
                     (cfg.origin == swtc_pkg::host_armed_probe_one) ||
                     (cfg.origin == swtc_pkg::host_armed_probe_two);
   end

   // Source selection for the comparator
   always_comb begin
      case (cfg.origin)
         swtc_pkg::probe_one_origin,
         swtc_pkg::host_armed_probe_one: src_sample = samples.probe_one;
         swtc_pkg::probe_two_origin,
         swtc_pkg::host_armed_probe_two: src_sample = samples.probe_two;
         swtc_pkg::rear_input_origin,
         swtc_pkg::host_armed_rear_input: src_sample = samples.rear;
         default: src_sample = samples.probe_one;
      endcase
   end

   // Tracking is on only with probes and in pulse mode
   assign tracking = cfg.pulse_mode && probe_origin &&
                     (cfg.beh == swtc_pkg::midpoint_tracking_behaviour);

   // Midpoint of the tracked extremes, or the host threshold
   always_comb begin
      mid_sum = {peak_max[15], peak_max} + {peak_min[15], peak_min};
      if (tracking && peak_seen) begin
         next_thresh = mid_sum[16:1];
      end else begin
         next_thresh = level;
      end
   end

   // Highest and lowest power seen while tracking
   always_ff @(posedge sys_clk) begin
      if (srst || !tracking) begin
         peak_seen <= 1'b0;
         peak_max <= 16'sh0000;
         peak_min <= 16'sh0000;
      end else if (samples.valid) begin
         peak_seen <= 1'b1;
         if (!peak_seen || src_sample > peak_max) begin
            peak_max <= src_sample;
         end
         if (!peak_seen || src_sample < peak_min) begin
            peak_min <= src_sample;
         end
      end
   end

   // Threshold register feeding the comparator
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         thresh <= swtc_pkg::LEVEL_RST;
      end else begin
         thresh <= next_thresh;
      end
   end

   // Comparator with hysteresis on the selected source
   swtc_edge_detect u_edge (
      .sys_clk(sys_clk),
      .srst(srst),
      .sample_valid(samples.valid),
      .sample(src_sample),
      .threshold(thresh),
      .hyst(hyst),
      .falling_polarity(cfg.falling_polarity),
      .edge_pulse(edge_pulse)
   );

   // Timeout length chosen by timespan
   assign limit = cfg.long_span ? swtc_pkg::TIMER_W'(TIMEOUT_LONG) :
                                  swtc_pkg::TIMER_W'(TIMEOUT_SHORT);
   assign timeout_on = edge_origin && (cfg.beh != swtc_pkg::edge_only_behaviour);

   // Sweep start causes, all gated by pulse mode and the armed state
   always_comb begin
      fire_edge = edge_pulse && (edge_origin || (armed_origin && host_arm));
      fire_force = timeout_on && (timer >= limit - 1'b1) && !fire_edge;
      fire_other = (cfg.origin == swtc_pkg::immediate_origin) ||
                   ((cfg.origin == swtc_pkg::bus_origin) && bus_pend);
      next_start = (state == st_armed) && cfg.pulse_mode &&
                   (fire_edge || fire_force || fire_other);
   end

   // Auto timeout counter, restarted by edges and forced sweeps
   // Held at zero while sweeping, out of pulse mode or with no timeout
   always_ff @(posedge sys_clk) begin
      if (srst || state != st_armed || !cfg.pulse_mode || !timeout_on) begin
         timer <= '0;
      end else if (fire_edge || fire_force || edge_pulse) begin
         timer <= '0;
      end else begin
         timer <= timer + 1'b1;
      end
   end

   // Armed and sweep states
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state <= st_armed;
      end else begin
         case (state)
            st_armed: begin
               // Any start cause leaves the armed state
               if (next_start) begin
                  state <= st_sweep;
               end
            end
            st_sweep: begin
               // Edges are not queued while sweeping, a bus command stays pending
               if (sweep_done) begin
                  state <= st_armed;
               end
            end
            default: state <= st_armed;
         endcase
      end
   end

   // Start pulse, armed flag, sweep count and cause of the last sweep
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sweep_start <= 1'b0;
         trig_armed <= 1'b0;
         sweep_count <= 32'h0000_0000;
         last_forced <= 1'b0;
      end else begin
         sweep_start <= next_start;
         trig_armed <= (state == st_armed) && !next_start && cfg.pulse_mode;
         if (next_start) begin
            sweep_count <= sweep_count + 32'h0000_0001;
            last_forced <= fire_force && !fire_edge;
         end
      end
   end

   // Host trigger command: bus trigger pending or hardware arm
   assign trg_write = wr_pend && (wr_addr == swtc_pkg::OFF_TRG);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bus_pend <= 1'b0;
         host_arm <= 1'b0;
      end else begin
         // A new command in the cycle it is consumed stays pending
         if (trg_write && cfg.origin == swtc_pkg::bus_origin) begin
            bus_pend <= 1'b1;
         end else if (next_start || cfg.origin != swtc_pkg::bus_origin) begin
            bus_pend <= 1'b0;
         end
         if (trg_write && armed_origin) begin
            host_arm <= 1'b1;
         end else if (next_start || !armed_origin) begin
            host_arm <= 1'b0;
         end
      end
   end

   // Bus address phase capture, zero wait states
   assign addr_take = hsel && htrans[1] && hready;

   // Address decoded every cycle, used only when a write is pending
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wr_pend <= 1'b0;
         wr_addr <= swtc_pkg::OFF_NONE;
      end else begin
         wr_pend <= addr_take && hwrite;
         wr_addr <= reg_decode(haddr);
      end
   end

   // Register writes in the data phase
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctrl <= swtc_pkg::CTRL_RST;
         level <= swtc_pkg::LEVEL_RST;
         hyst <= swtc_pkg::HYST_RST;
      end else if (wr_pend) begin
         case (wr_addr)
            swtc_pkg::OFF_CTRL: begin
               // Only the defined fields are stored, the rest read 0
               ctrl <= {22'h00_0000, hwdata[9:8], 1'b0, hwdata[6:4], 1'b0, hwdata[2:0]};
            end
            swtc_pkg::OFF_LEVEL: begin
               level <= hwdata[15:0];
               if (cfg.beh == swtc_pkg::midpoint_tracking_behaviour) begin
                  ctrl[swtc_pkg::CTRL_BEH_LSB +: 2] <= swtc_pkg::auto_behaviour;
               end
            end
            swtc_pkg::OFF_HYST: hyst <= hwdata[15:0];
            default: begin
               // Read-only, command or unmapped: nothing stored
            end
         endcase
      end
   end

   // Status word, fields at their package positions
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[swtc_pkg::STAT_ARMED_BIT] = (state == st_armed);
      status_word[swtc_pkg::STAT_BUSY_BIT] = (state == st_sweep);
      status_word[swtc_pkg::STAT_HARM_BIT] = host_arm;
      status_word[swtc_pkg::STAT_BUSP_BIT] = bus_pend;
      status_word[swtc_pkg::STAT_FORCED_BIT] = last_forced;
   end

   // Read data taken from the address phase, bus answer always OKAY
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (addr_take && !hwrite) begin
            case (reg_decode(haddr))
               swtc_pkg::OFF_CTRL: hrdata <= ctrl;
               swtc_pkg::OFF_LEVEL: hrdata <= {16'h0000, level};
               swtc_pkg::OFF_HYST: hrdata <= {16'h0000, hyst};
               swtc_pkg::OFF_STATUS: hrdata <= status_word;
               swtc_pkg::OFF_THRESH: hrdata <= {16'h0000, thresh};
               swtc_pkg::OFF_COUNT: hrdata <= sweep_count;
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule : swtc_sweep_trigger

// >>> bench/swtc_acq_model.sv
`timescale 1ns/1ns

// Acquisition side: ends each sweep a set number of cycles after it began
module swtc_acq_model (
   input wire logic sys_clk, // System clock
   input wire logic srst, // Synchronous reset
   input wire logic sweep_start, // Sweep begins
   input wire logic [7:0] dly, // Sweep length in cycles
   output logic sweep_done // One-cycle end of sweep
);
   logic [7:0] left; // Cycles still to run
   logic busy; // Sweep in progress

   // One done pulse per started sweep, never while idle
   always_ff @(posedge sys_clk) begin
      sweep_done <= 1'b0;
      if (srst) begin
         busy <= 1'b0;
      end else if (sweep_start) begin
         busy <= 1'b1;
         left <= dly;
      end else if (busy && left == 8'h00) begin
         busy <= 1'b0;
         sweep_done <= 1'b1;
      end else if (busy) begin
         left <= left - 8'h01;
      end
   end
endmodule : swtc_acq_model

// >>> bench/swtc_sva.sv
`timescale 1ns/1ns

// Port-level checks of the sweep trigger
module swtc_sva (
   input wire logic sys_clk, // System clock
   input wire logic srst, // Synchronous reset
   input wire logic hsel, // Slave select
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write flag
   input wire logic hready, // Bus ready
   input wire logic hreadyout, // Slave ready
   input wire logic [31:0] hrdata, // Read data
   input wire logic hresp, // Response
   input wire logic sweep_done, // End of sweep
   input wire logic sweep_start, // Sweep start pulse
   input wire logic trig_armed // Armed level
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);

   logic in_sweep; // Between a start and its done

   // Tracks the sweep in flight
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         in_sweep <= 1'b0;
      end else if (sweep_start) begin
         in_sweep <= 1'b1;
      end else if (sweep_done) begin
         in_sweep <= 1'b0;
      end
   end

   sequence s_pulse;
      sweep_start ##1 !sweep_start;
   endsequence
   sequence s_rearm;
      ##[1:2] (trig_armed || sweep_start);
   endsequence

   okay_resp_a: assert property (hresp == 1'b0) else $error("error response");
   zero_wait_a: assert property (hreadyout) else $error("wait state");
   rdata_hold_a: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
      else $error("read data moved");
   reset_quiet_a: assert property ($fell(srst) |-> !sweep_start && !trig_armed &&
                                   hrdata == 32'h0000_0000)
      else $error("outputs busy after reset");
   reset_arm_a: assert property ($fell(srst) |=> trig_armed || sweep_start)
      else $error("not armed after reset");
   start_pulse_a: assert property (sweep_start |-> s_pulse)
      else $error("start longer than one cycle");
   one_per_sweep_a: assert property (in_sweep |-> !sweep_start)
      else $error("second start in one sweep");
   disarm_start_a: assert property (sweep_start |=> !trig_armed)
      else $error("armed during sweep");
   rearm_done_a: assert property (in_sweep && sweep_done |-> s_rearm)
      else $error("no rearm after done");
endmodule : swtc_sva

bind swtc_sweep_trigger swtc_sva swtc_sva_i (.sys_clk, .srst, .hsel, .htrans, .hwrite,
   .hready, .hreadyout, .hrdata, .hresp, .sweep_done, .sweep_start, .trig_armed);

// >>> bench/swtc_sweep_trigger_tb_top.sv
`timescale 1ns/1ns

// Self-checking bench of the sweep trigger
module swtc_sweep_trigger_tb_top;
   logic sys_clk, srst, hsel, hwrite, hreadyout, hresp, sweep_done, sweep_start, trig_armed;
   logic [31:0] haddr, hwdata, hrdata, rd_val, ec;
   logic [1:0] htrans;
   logic [2:0] hsize; // Transfer size, whole words only
   logic [7:0] dly; // Sweep length of the model
   logic [15:0] seed; // Random state
   logic [63:0] pair; // Expected value and mask
   logic [63:0] exp_q[$]; // Pending expectations
   swtc_pkg::swtc_samples_t samples;
   int fail_count, cmp_count;
   event got_ev; // A read has finished

   swtc_sweep_trigger #(.TIMEOUT_SHORT(50), .TIMEOUT_LONG(200)) swtc_sweep_trigger_i (
      .sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .samples, .sweep_done,
      .sweep_start, .trig_armed);
   swtc_acq_model swtc_acq_model_i (.sys_clk, .srst, .sweep_start, .dly, .sweep_done);

   // Free-running 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Pseudo-random step
   function logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : idle

   // One single AHB transfer, held until ready
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd_val = hrdata;
   endtask : bus

   // Read a register and note what it should hold
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
      exp_q.push_back({e, m});
      bus(1'b0, a, 32'h0);
      ->got_ev;
   endtask : rd

   // Host trigger command with random ignored data
   task trg;
      seed = lfsr(seed);
      bus(1'b1, swtc_pkg::OFF_TRG, {16'h0, seed});
      idle(4);
   endtask : trg

   // Low, high, low on one source, then time for the sweep
   task swing(input int s, input logic [15:0] lo, input logic [15:0] hi);
      for (int i = 0; i < 3; i++) begin
         case (s)
            0: samples.probe_one <= (i == 1) ? hi : lo;
            1: samples.probe_two <= (i == 1) ? hi : lo;
            default: samples.rear <= (i == 1) ? hi : lo;
         endcase
         idle(3);
      end
      idle(25);
   endtask : swing

   // Compares each finished read with the oldest note
   always @(got_ev) begin
      pair = exp_q.pop_front();
      cmp_count++;
      if ((rd_val & pair[31:0]) !== (pair[63:32] & pair[31:0])) begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, rd_val, pair[63:32]);
      end
   end

   task summarize;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   // Cuts a hang short
   initial begin
      idle(6000);
      fail_count++;
      summarize();
   end

   // Main sequence
   initial begin
      srst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      samples = '0;
      samples.valid = 1'b1;
      dly = 8'h08;
      seed = 16'h5cc0;
      ec = 32'h0;
      idle(2);
      srst <= 1'b0;
      idle(1);
      rd(swtc_pkg::OFF_CTRL, 32'h101);
      rd(swtc_pkg::OFF_LEVEL, 32'h0);
      rd(swtc_pkg::OFF_HYST, 32'h10);
      rd(swtc_pkg::OFF_COUNT, 32'h0);
      trg();
      bus(1'b1, 8'h20, {seed, 16'h0});
      rd(8'h20, 32'h0);
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h100);
      bus(1'b1, swtc_pkg::OFF_LEVEL, 32'h64);
      swing(0, 16'h0, 16'h006e);
      rd(swtc_pkg::OFF_COUNT, ec);
      swing(0, 16'h0, 16'h0074);
      ec++;
      rd(swtc_pkg::OFF_COUNT, ec);
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h104);
      swing(0, 16'h0, 16'h00c8);
      ec++;
      rd(swtc_pkg::OFF_COUNT, ec);
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h110);
      swing(0, 16'h0, 16'h00c8);
      swing(1, 16'h0, 16'h00c8);
      ec++;
      rd(swtc_pkg::OFF_COUNT, ec);
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h120);
      swing(1, 16'h0, 16'h00c8);
      swing(2, 16'h0, 16'h00c8);
      ec++;
      rd(swtc_pkg::OFF_COUNT, ec);
      idle(200);
      rd(swtc_pkg::OFF_COUNT, ec);
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h140);
      trg();
      ec++;
      rd(swtc_pkg::OFF_COUNT, ec);
      idle(20);
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h150);
      swing(0, 16'h0, 16'h00c8);
      trg();
      swing(0, 16'h0, 16'h00c8);
      ec++;
      rd(swtc_pkg::OFF_COUNT, ec);
      dly <= 8'h3c;
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h130);
      idle(5);
      ec++;
      rd(swtc_pkg::OFF_COUNT, ec);
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h100);
      idle(70);
      rd(swtc_pkg::OFF_COUNT, ec);
      dly <= 8'h1e;
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h030);
      idle(100);
      rd(swtc_pkg::OFF_COUNT, ec);
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h301);
      idle(150);
      rd(swtc_pkg::OFF_COUNT, ec);
      idle(60);
      ec++;
      rd(swtc_pkg::OFF_COUNT, ec);
      idle(30);
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h030);
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h101);
      idle(150);
      ec = ec + 32'h2;
      rd(swtc_pkg::OFF_COUNT, ec);
      rd(swtc_pkg::OFF_STATUS, 32'h10, 32'h10);
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h102);
      swing(0, 16'hff38, 16'h0190);
      rd(swtc_pkg::OFF_THRESH, 32'h64, 32'hffff);
      bus(1'b1, swtc_pkg::OFF_LEVEL, 32'h32);
      rd(swtc_pkg::OFF_CTRL, 32'h101);
      rd(swtc_pkg::OFF_THRESH, 32'h32, 32'hffff);
      bus(1'b1, swtc_pkg::OFF_CTRL, 32'h122);
      swing(2, 16'hff38, 16'h0190);
      rd(swtc_pkg::OFF_THRESH, 32'h32, 32'hffff);
      idle(2);
      summarize();
   end
endmodule : swtc_sweep_trigger_tb_top
